/* odp_params.svh */
// constants for the operand format datapath: bus map, field positions, codes and limits
// assumes a single 100 MHz clock domain; included by bare name from every design file but the package and the memory model
`ifndef ODP_PARAMS_SVH
`define ODP_PARAMS_SVH

// register port map, byte-free word addresses
`define ODP_ADR_STATUS 8'h20
`define ODP_ADR_CMD_HI 8'h21
`define ODP_ADR_CMD_LO 8'h22
`define ODP_GR_PAGE 4'h0

// status word layout
`define ODP_STAT_CC 3:0
`define ODP_STAT_BUSY 4
`define ODP_STAT_AERR 5
`define ODP_STAT_ILL 6
`define ODP_CC_C 3
`define ODP_CC_V 2
`define ODP_CC_G 1
`define ODP_CC_L 0

// instruction fields within the first halfword and within its opcode byte
`define ODP_F_OP 15:8
`define ODP_F_R1 7:4
`define ODP_F_R2 3:0
`define ODP_F_LAYOUT 7:6
`define ODP_F_CLASS 5:4
`define ODP_F_FN 3:0

// layout codes in the top two opcode bits
`define ODP_LAY_RR 2'h0
`define ODP_LAY_RX 2'h1
`define ODP_LAY_RS 2'h2

// operand classes
`define ODP_CL_HALF 2'h0
`define ODP_CL_BYTE 2'h1
`define ODP_CL_FLOAT 2'h2

// function codes
`define ODP_FN_LOAD 4'h0
`define ODP_FN_ADD 4'h1
`define ODP_FN_AND 4'h2
`define ODP_FN_OR 4'h3
`define ODP_FN_XOR 4'h4
`define ODP_FN_CMPL 4'h5
`define ODP_FN_STORE 4'h6
`define ODP_FN_SUB 4'h7

// floating format limits, exponents held as 10-bit two's complement
`define ODP_FP_BIAS 10'h040
`define ODP_EXP_MAX 10'h03F
`define ODP_EXP_MIN 10'h3C0
`define ODP_EXP_ONES 7'h7F
`define ODP_FRAC_ONES 24'hFFFFFF
`define ODP_FRAC_DIGITS 7'h06

// alignment masks
`define ODP_HALF_MASK 16'h0001
`define ODP_FULL_MASK 16'h0003
`define ODP_HALF_STEP 16'h0002

`endif

/* odp_pkg.sv */
// types shared by the operand format datapath modules
// does not include odp_params.svh; its widths are written out directly
package odp_pkg;

	// one floating value in its two-halfword image
	typedef struct packed {
		logic sign;
		logic [6:0] exp;
		logic [23:0] frac;
	} odp_fp_t;

	typedef enum logic [1:0] {ODP_SZ_BYTE, ODP_SZ_HALF, ODP_SZ_FULL} odp_size_t;

	typedef enum logic [1:0] {ODP_MP_IDLE, ODP_MP_FIRST, ODP_MP_SECOND} odp_mp_st_t;

	typedef enum logic [2:0] {ODP_ST_IDLE, ODP_ST_ADDR, ODP_ST_READ, ODP_ST_EXEC, ODP_ST_WRITE} odp_core_st_t;

	// memory port state
	typedef struct packed {
		odp_mp_st_t st;
		logic [15:0] addr;
		logic we;
		odp_size_t sz;
		logic [31:0] wd;
		logic [15:0] mwd;
		logic [15:0] hi;
		logic [31:0] rd;
		logic done;
		logic err;
	} odp_mp_t;

	// datapath state
	typedef struct packed {
		odp_core_st_t st;
		logic [15:0] ihi;
		logic [15:0] ilo;
		logic [15:0][15:0] gr;
		odp_fp_t [7:0] fpr;
		logic [15:0] ea;
		logic [31:0] opnd;
		logic [3:0] cc;
		logic aerr;
		logic ill;
		logic [15:0] rdata;
		logic mreq;
		logic mwe;
		odp_size_t msz;
		logic [31:0] mwd;
	} odp_core_t;

endpackage : odp_pkg

/* odp_fp_norm.sv */
// post-normalizer for floating results, with exponent range handling
// purely combinational; exponent arrives unbiased as 10-bit two's complement
`include "odp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module odp_fp_norm (
	// raw result
	input wire logic sign_i,
	input wire logic [9:0] exp_i,
	input wire logic [27:0] frac_i,
	// normalized result
	output var odp_pkg::odp_fp_t res_o,
	output logic ovf_o
);

	logic [27:0] f;
	logic [9:0] e;
	logic [9:0] eb;

	// shift by whole hex digits until the leading digit is nonzero
	always_comb begin
		f = frac_i;
		e = exp_i;
		if (f[27:24] != 4'h0) begin
			f = f >> 4;
			e = e + 10'h001;
		end
		for (int i = 0; i < 6; i++) begin
			if (f[23:20] == 4'h0 && f != 28'h0000000) begin
				f = f << 4;
				e = e - 10'h001;
			end
		end
		eb = e + `ODP_FP_BIAS;
		ovf_o = 1'b0;
		if (f == 28'h0000000) begin
			res_o = '0;
		end else if ($signed(e) > $signed(`ODP_EXP_MAX)) begin
			res_o = {sign_i, `ODP_EXP_ONES, `ODP_FRAC_ONES};
			ovf_o = 1'b1;
		end else if ($signed(e) < $signed(`ODP_EXP_MIN)) begin
			res_o = '0;
			ovf_o = 1'b1;
		end else begin
			res_o = {sign_i, eb[6:0], f[23:0]};
		end
	end

endmodule : odp_fp_norm
`default_nettype wire

/* odp_mem_port.sv */
// halfword memory sequencer: byte, halfword and fullword operands over a 16-bit bus
// memory shares the clock; it holds MEM_ACK for one cycle per halfword transfer
`include "odp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module odp_mem_port (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// request from the datapath
	input wire logic req_i,
	input wire logic we_i,
	input wire odp_pkg::odp_size_t sz_i,
	input wire logic [15:0] addr_i,
	input wire logic [31:0] wdata_i,
	output logic done_o,
	output logic err_o,
	output logic [31:0] rdata_o,
	// memory bus
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [15:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_rdata_i
);

	odp_pkg::odp_mp_t s;
	odp_pkg::odp_mp_t n;

	function automatic logic misaligned(input odp_pkg::odp_size_t sz, input logic [15:0] a);
		misaligned = (sz == odp_pkg::ODP_SZ_HALF && (a & `ODP_HALF_MASK) != 16'h0000) ||
			(sz == odp_pkg::ODP_SZ_FULL && (a & `ODP_FULL_MASK) != 16'h0000);
	endfunction : misaligned

	// sequencing; the bus address always has its low bit cleared since transfers are halfwords
	always_comb begin
		n = s;
		n.done = 1'b0;
		n.err = 1'b0;
		unique case (s.st)
			odp_pkg::ODP_MP_IDLE: begin
				if (req_i) begin
					if (misaligned(sz_i, addr_i)) begin
						n.done = 1'b1;
						n.err = 1'b1;
					end else begin
						n.st = odp_pkg::ODP_MP_FIRST;
						n.addr = addr_i;
						n.we = we_i;
						n.sz = sz_i;
						n.wd = wdata_i;
						n.mwd = (sz_i == odp_pkg::ODP_SZ_FULL) ? wdata_i[31:16] : wdata_i[15:0];
					end
				end
			end
			odp_pkg::ODP_MP_FIRST: begin
				if (mem_ack_i) begin
					if (s.sz == odp_pkg::ODP_SZ_FULL) begin
						n.st = odp_pkg::ODP_MP_SECOND;
						n.hi = mem_rdata_i;
						n.addr = s.addr + `ODP_HALF_STEP;
						n.mwd = s.wd[15:0];
					end else begin
						n.st = odp_pkg::ODP_MP_IDLE;
						n.done = 1'b1;
						if (s.sz == odp_pkg::ODP_SZ_BYTE) begin
							n.rd = {24'h000000, s.addr[0] ? mem_rdata_i[7:0] : mem_rdata_i[15:8]};
						end else begin
							n.rd = {16'h0000, mem_rdata_i};
						end
					end
				end
			end
			odp_pkg::ODP_MP_SECOND: begin
				if (mem_ack_i) begin
					n.st = odp_pkg::ODP_MP_IDLE;
					n.done = 1'b1;
					n.rd = {s.hi, mem_rdata_i};
				end
			end
			default: n.st = odp_pkg::ODP_MP_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign done_o = s.done;
	assign err_o = s.err;
	assign rdata_o = s.rd;
	assign mem_req_o = (s.st != odp_pkg::ODP_MP_IDLE);
	assign mem_we_o = s.we && (s.st != odp_pkg::ODP_MP_IDLE);
	assign mem_addr_o = s.addr & ~`ODP_HALF_MASK;
	assign mem_wdata_o = s.mwd;

endmodule : odp_mem_port
`default_nettype wire

/* odp_datapath.sv */
// operand format datapath: decodes one instruction, fetches its operands, executes it
// software loads the instruction over the register port; memory sits on a halfword bus
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`include "odp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module odp_datapath (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	// register port
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [15:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [15:0] REG_RDATA_O,
	// halfword memory bus
	output logic MEM_REQ_O,
	output logic MEM_WE_O,
	output logic [15:0] MEM_ADDR_O,
	output logic [15:0] MEM_WDATA_O,
	input wire logic MEM_ACK_I,
	input wire logic [15:0] MEM_RDATA_I
);

	odp_pkg::odp_core_t s;
	odp_pkg::odp_core_t n;

	logic [7:0] operation_code_field;
	logic [3:0] first_operand_reg_field;
	logic [3:0] second_operand_reg_field;
	logic [3:0] index_reg_field;
	logic [1:0] layout;
	logic [1:0] op_class;
	logic [3:0] fn;
	logic [15:0] index_val;
	logic [15:0] eff_addr;
	logic busy;
	logic mp_done;
	logic mp_err;
	logic [31:0] mp_rdata;
	odp_pkg::odp_fp_t fa;
	odp_pkg::odp_fp_t fb;
	odp_pkg::odp_fp_t fp_res;
	logic fp_ovf;
	logic norm_sign;
	logic [9:0] norm_exp;
	logic [27:0] norm_frac;
	logic sb;
	logic [27:0] ma;
	logic [27:0] mb;
	logic [15:0] h_a;
	logic [15:0] h_b;
	logic [16:0] h_sum;
	logic [7:0] b_b;

	// shift a fraction right by whole hex digits, losing it past six digits
	function automatic logic [27:0] shr_digits(input logic [23:0] f, input logic [6:0] d);
		if (d > `ODP_FRAC_DIGITS) begin
			shr_digits = 28'h0000000;
		end else begin
			shr_digits = {4'h0, f} >> {d[2:0], 2'b00};
		end
	endfunction : shr_digits

	// which combinations of layout, class and function exist
	function automatic logic legal(input logic [1:0] lay, input logic [1:0] cl, input logic [3:0] f);
		legal = 1'b0;
		if (lay != 2'h3) begin
			if (cl == `ODP_CL_FLOAT) begin
				legal = (lay == `ODP_LAY_RR && (f == `ODP_FN_LOAD || f == `ODP_FN_ADD || f == `ODP_FN_SUB)) ||
					(lay == `ODP_LAY_RX && (f == `ODP_FN_LOAD || f == `ODP_FN_ADD || f == `ODP_FN_SUB ||
					f == `ODP_FN_STORE));
			end else if (cl == `ODP_CL_HALF) begin
				legal = (f <= `ODP_FN_CMPL) || (f == `ODP_FN_STORE && lay == `ODP_LAY_RX);
			end else if (cl == `ODP_CL_BYTE) begin
				legal = (f == `ODP_FN_LOAD || (f >= `ODP_FN_AND && f <= `ODP_FN_CMPL));
			end
		end
	endfunction : legal

	// field decode; the register layout uses only the first halfword
	assign operation_code_field = s.ihi[`ODP_F_OP];
	assign first_operand_reg_field = s.ihi[`ODP_F_R1];
	assign second_operand_reg_field = s.ihi[`ODP_F_R2];
	assign index_reg_field = s.ihi[`ODP_F_R2];
	assign layout = operation_code_field[`ODP_F_LAYOUT];
	assign op_class = operation_code_field[`ODP_F_CLASS];
	assign fn = operation_code_field[`ODP_F_FN];
	assign busy = (s.st != odp_pkg::ODP_ST_IDLE);

	// index register zero means no indexing
	assign index_val = (index_reg_field != 4'h0) ? s.gr[index_reg_field] : 16'h0000;
	assign eff_addr = s.ilo + index_val;

	// floating operands: register number bit 0 is ignored so odd selects the lower even one
	assign fa = s.fpr[first_operand_reg_field[3:1]];
	assign fb = (layout == `ODP_LAY_RR) ? s.fpr[second_operand_reg_field[3:1]] : s.opnd;

	// floating path: align by hex digits and add or subtract magnitudes; no pre-normalization
	always_comb begin
		sb = fb.sign ^ (fn == `ODP_FN_SUB);
		ma = 28'h0000000;
		mb = 28'h0000000;
		norm_sign = fb.sign;
		norm_exp = {3'h0, fb.exp} - `ODP_FP_BIAS;
		norm_frac = {4'h0, fb.frac};
		if (fn != `ODP_FN_LOAD) begin
			if (fa.exp >= fb.exp) begin
				ma = {4'h0, fa.frac};
				mb = shr_digits(fb.frac, fa.exp - fb.exp);
				norm_exp = {3'h0, fa.exp} - `ODP_FP_BIAS;
			end else begin
				ma = shr_digits(fa.frac, fb.exp - fa.exp);
				mb = {4'h0, fb.frac};
			end
			if (fa.sign == sb) begin
				norm_sign = fa.sign;
				norm_frac = ma + mb;
			end else if (ma >= mb) begin
				norm_sign = fa.sign;
				norm_frac = ma - mb;
			end else begin
				norm_sign = sb;
				norm_frac = mb - ma;
			end
		end
	end

	// one normalizer serves load and arithmetic alike
	odp_fp_norm u_norm (
		.sign_i(norm_sign),
		.exp_i(norm_exp),
		.frac_i(norm_frac),
		.res_o(fp_res),
		.ovf_o(fp_ovf)
	);

	// halfword and byte second operands: register, memory, or the address sum itself
	always_comb begin
		h_a = s.gr[first_operand_reg_field];
		if (layout == `ODP_LAY_RR) begin
			h_b = s.gr[second_operand_reg_field];
		end else if (layout == `ODP_LAY_RX) begin
			h_b = s.opnd[15:0];
		end else begin
			h_b = s.ea;
		end
		b_b = h_b[7:0];
		h_sum = {1'b0, h_a} + {1'b0, h_b};
	end

	// main sequencing, register port and execution
	always_comb begin
		n = s;
		n.mreq = 1'b0;
		if (REG_WR_I) begin
			if (REG_ADDR_I[7:4] == `ODP_GR_PAGE) begin
				n.gr[REG_ADDR_I[3:0]] = REG_WDATA_I;
			end else if (REG_ADDR_I == `ODP_ADR_STATUS) begin
				n.aerr = s.aerr & ~REG_WDATA_I[`ODP_STAT_AERR];
				n.ill = s.ill & ~REG_WDATA_I[`ODP_STAT_ILL];
			end else if (REG_ADDR_I == `ODP_ADR_CMD_LO && !busy) begin
				n.ilo = REG_WDATA_I;
			end else if (REG_ADDR_I == `ODP_ADR_CMD_HI && !busy) begin
				n.ihi = REG_WDATA_I;
				n.st = odp_pkg::ODP_ST_ADDR;
			end
		end
		if (REG_RD_I) begin
			// floating registers are deliberately absent from this map
			if (REG_ADDR_I[7:4] == `ODP_GR_PAGE) begin
				n.rdata = s.gr[REG_ADDR_I[3:0]];
			end else if (REG_ADDR_I == `ODP_ADR_STATUS) begin
				n.rdata = {9'h000, s.ill, s.aerr, busy, s.cc};
			end else if (REG_ADDR_I == `ODP_ADR_CMD_HI) begin
				n.rdata = s.ihi;
			end else if (REG_ADDR_I == `ODP_ADR_CMD_LO) begin
				n.rdata = s.ilo;
			end else begin
				n.rdata = 16'h0000;
			end
		end
		unique case (s.st)
			odp_pkg::ODP_ST_IDLE: begin
			end
			odp_pkg::ODP_ST_ADDR: begin
				n.ea = eff_addr;
				if (!legal(layout, op_class, fn)) begin
					n.ill = 1'b1;
					n.st = odp_pkg::ODP_ST_IDLE;
				end else if (layout == `ODP_LAY_RX) begin
					n.mreq = 1'b1;
					n.mwe = (fn == `ODP_FN_STORE);
					if (op_class == `ODP_CL_FLOAT) begin
						n.msz = odp_pkg::ODP_SZ_FULL;
						n.mwd = fa;
					end else if (op_class == `ODP_CL_BYTE) begin
						n.msz = odp_pkg::ODP_SZ_BYTE;
						n.mwd = {16'h0000, h_a};
					end else begin
						n.msz = odp_pkg::ODP_SZ_HALF;
						n.mwd = {16'h0000, h_a};
					end
					n.st = (fn == `ODP_FN_STORE) ? odp_pkg::ODP_ST_WRITE : odp_pkg::ODP_ST_READ;
				end else begin
					n.st = odp_pkg::ODP_ST_EXEC;
				end
			end
			odp_pkg::ODP_ST_READ: begin
				if (mp_done) begin
					n.opnd = mp_rdata;
					if (mp_err) begin
						n.aerr = 1'b1;
						n.st = odp_pkg::ODP_ST_IDLE;
					end else begin
						n.st = odp_pkg::ODP_ST_EXEC;
					end
				end
			end
			odp_pkg::ODP_ST_WRITE: begin
				if (mp_done) begin
					if (mp_err) begin
						n.aerr = 1'b1;
					end
					n.st = odp_pkg::ODP_ST_IDLE;
				end
			end
			odp_pkg::ODP_ST_EXEC: begin
				n.st = odp_pkg::ODP_ST_IDLE;
				if (op_class == `ODP_CL_FLOAT) begin
					n.fpr[first_operand_reg_field[3:1]] = fp_res;
					n.cc = {1'b0, fp_ovf, !fp_res.sign && fp_res != '0, fp_res.sign};
				end else if (op_class == `ODP_CL_BYTE) begin
					unique case (fn)
						`ODP_FN_LOAD: n.gr[first_operand_reg_field] = {8'h00, b_b};
						`ODP_FN_AND: n.gr[first_operand_reg_field][7:0] = h_a[7:0] & b_b;
						`ODP_FN_OR: n.gr[first_operand_reg_field][7:0] = h_a[7:0] | b_b;
						`ODP_FN_XOR: n.gr[first_operand_reg_field][7:0] = h_a[7:0] ^ b_b;
						default: begin
						end
					endcase
					n.cc = {2'h0, h_a[7:0] > b_b, h_a[7:0] < b_b};
					if (fn != `ODP_FN_CMPL) begin
						n.cc = {2'h0, n.gr[first_operand_reg_field][7:0] != 8'h00, 1'b0};
					end
				end else begin
					unique case (fn)
						`ODP_FN_LOAD: n.gr[first_operand_reg_field] = h_b;
						`ODP_FN_ADD: n.gr[first_operand_reg_field] = h_sum[15:0];
						`ODP_FN_AND: n.gr[first_operand_reg_field] = h_a & h_b;
						`ODP_FN_OR: n.gr[first_operand_reg_field] = h_a | h_b;
						`ODP_FN_XOR: n.gr[first_operand_reg_field] = h_a ^ h_b;
						default: begin
						end
					endcase
					if (fn == `ODP_FN_CMPL) begin
						n.cc = {2'h0, h_a > h_b, h_a < h_b};
					end else begin
						n.cc[`ODP_CC_G] = !n.gr[first_operand_reg_field][15] &&
							n.gr[first_operand_reg_field] != 16'h0000;
						n.cc[`ODP_CC_L] = n.gr[first_operand_reg_field][15];
						n.cc[`ODP_CC_C] = (fn == `ODP_FN_ADD) && h_sum[16];
						n.cc[`ODP_CC_V] = (fn == `ODP_FN_ADD) && (h_a[15] == h_b[15]) && (h_sum[15] != h_a[15]);
					end
				end
			end
			default: n.st = odp_pkg::ODP_ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// halfword memory sequencer
	odp_mem_port u_mem (
		.clk_i(REF_CLK_I),
		.rst_i(SYS_RST_I),
		.req_i(s.mreq),
		.we_i(s.mwe),
		.sz_i(s.msz),
		.addr_i(s.ea),
		.wdata_i(s.mwd),
		.done_o(mp_done),
		.err_o(mp_err),
		.rdata_o(mp_rdata),
		.mem_req_o(MEM_REQ_O),
		.mem_we_o(MEM_WE_O),
		.mem_addr_o(MEM_ADDR_O),
		.mem_wdata_o(MEM_WDATA_O),
		.mem_ack_i(MEM_ACK_I),
		.mem_rdata_i(MEM_RDATA_I)
	);

	assign REG_RDATA_O = s.rdata;

endmodule : odp_datapath
`default_nettype wire

/* odp_datapath_chk.sv */
// checker: memory bus pacing and alignment, register port answers
// sees only the top ports; bound to odp_datapath at the foot
`include "odp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module odp_datapath_chk (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	// register port
	input wire logic [7:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [15:0] REG_RDATA_O,
	// memory bus
	input wire logic MEM_REQ_O,
	input wire logic MEM_WE_O,
	input wire logic [15:0] MEM_ADDR_O,
	input wire logic [15:0] MEM_WDATA_O,
	input wire logic MEM_ACK_I
);
	logic [1:0] acks_r;

	// acks within one request; a third would mean an overlong transfer
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I)
			acks_r <= 2'h0;
		else if (!MEM_REQ_O)
			acks_r <= 2'h0;
		else if (MEM_ACK_I)
			acks_r <= acks_r + 2'h1;
	end

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	property p_half_even;
		MEM_REQ_O |-> !MEM_ADDR_O[0];
	endproperty
	a_half_even: assert property (p_half_even)
		else $error("odd memory address");
	property p_addr_hold;
		MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O) && $stable(MEM_WE_O);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("request changed before ack");
	property p_wdata_hold;
		MEM_REQ_O && MEM_WE_O && !MEM_ACK_I |=> $stable(MEM_WDATA_O);
	endproperty
	a_wdata_hold: assert property (p_wdata_hold)
		else $error("write data changed before ack");
	property p_second_half;
		MEM_REQ_O && MEM_ACK_I ##1 MEM_REQ_O |-> MEM_ADDR_O == $past(MEM_ADDR_O) + 16'h0002;
	endproperty
	a_second_half: assert property (p_second_half)
		else $error("second halfword not at next address");
	property p_full_align;
		MEM_REQ_O && MEM_ACK_I ##1 MEM_REQ_O |-> $past(MEM_ADDR_O[1]) == 1'b0;
	endproperty
	a_full_align: assert property (p_full_align)
		else $error("fullword not on a multiple of four");
	property p_two_acks;
		MEM_REQ_O |-> acks_r != 2'h2;
	endproperty
	a_two_acks: assert property (p_two_acks)
		else $error("more than two halfwords in one request");
	property p_req_cause;
		$rose(MEM_REQ_O) |-> $past(REG_WR_I && REG_ADDR_I == `ODP_ADR_CMD_HI, 3);
	endproperty
	a_req_cause: assert property (p_req_cause)
		else $error("memory request without an instruction start");
	property p_unmapped;
		REG_RD_I && REG_ADDR_I inside {[8'h10:8'h1F], [8'h23:8'hFF]} |=> REG_RDATA_O == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
endmodule : odp_datapath_chk

bind odp_datapath odp_datapath_chk odp_datapath_chk_inst (
	.REF_CLK_I, .SYS_RST_I, .REG_ADDR_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O,
	.MEM_REQ_O, .MEM_WE_O, .MEM_ADDR_O, .MEM_WDATA_O, .MEM_ACK_I
);
`default_nettype wire

/* odp_mem_model.sv */
// partner model: halfword core memory on the datapath's memory bus
// shares the datapath clock; the bench sets contents and pacing directly
`timescale 1ns/1ps
`default_nettype none

module odp_mem_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// cycles waited before each ack
	input wire logic [3:0] wait_i,
	// memory bus
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic ack_o,
	output logic [15:0] rdata_o
);
	logic [15:0] mem [0:32767];
	logic [3:0] wait_cnt;

	// one halfword per ack; read data valid only in the ack cycle, toggling otherwise
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			wait_cnt <= 4'h0;
			rdata_o <= 16'h0000;
		end else if (ack_o || !req_i || wait_cnt < wait_i) begin
			ack_o <= 1'b0;
			wait_cnt <= (ack_o || !req_i) ? 4'h0 : wait_cnt + 4'h1;
			rdata_o <= ~rdata_o;
		end else begin
			ack_o <= 1'b1;
			wait_cnt <= 4'h0;
			rdata_o <= we_i ? ~rdata_o : mem[addr_i[15:1]];
			if (we_i)
				mem[addr_i[15:1]] <= wdata_i;
		end
	end
endmodule : odp_mem_model
`default_nettype wire

/* odp_datapath_test.sv */
// self-checking bench for the operand format datapath
// drives the register port; the memory model answers the halfword bus
`include "odp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module odp_datapath_test;
	logic clk, rst, reg_wr, reg_rd, mem_req, mem_we, mem_ack;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, s, a, x, y, res;
	logic [3:0] mem_wait, r1, xr, fn;
	logic [1:0] cls;
	logic [31:0] seed = 32'h17;
	logic [31:0] t, v;
	logic [32:0] ne;
	logic [15:0] gr [0:15];
	logic [31:0] fa [0:3] = '{32'hFF800000, 32'h41100000, 32'h00110000, 32'h41180000};
	logic [31:0] fb [0:3] = '{32'hFF800000, 32'h41100000, 32'h00100000, 32'h41100000};
	logic [3:0] ff [0:3] = '{`ODP_FN_ADD, `ODP_FN_SUB, `ODP_FN_SUB, `ODP_FN_SUB};
	logic [32:0] fx [0:3] = '{{1'b1, 32'hFFFFFFFF}, 33'h0, {1'b1, 32'h0}, {1'b0, 32'h40800000}};
	int fail_count, compares, req_cycles;

	odp_datapath odp_datapath_inst (.REF_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(reg_addr),
		.REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata),
		.MEM_REQ_O(mem_req), .MEM_WE_O(mem_we), .MEM_ADDR_O(mem_addr), .MEM_WDATA_O(mem_wdata),
		.MEM_ACK_I(mem_ack), .MEM_RDATA_I(mem_rdata));
	odp_mem_model odp_mem_model_inst (.clk_i(clk), .rst_i(rst), .wait_i(mem_wait), .req_i(mem_req),
		.we_i(mem_we), .addr_i(mem_addr), .wdata_i(mem_wdata), .ack_o(mem_ack), .rdata_o(mem_rdata));

	// 100 MHz reference clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// bus cycles, to show refused accesses stay off it
	always @(posedge clk)
		if (mem_req === 1'b1)
			req_cycles++;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	function automatic logic [15:0] lop(input logic [3:0] f, input logic [15:0] p, input logic [15:0] q);
		case (f)
			`ODP_FN_AND: return p & q;
			`ODP_FN_OR: return p | q;
			`ODP_FN_XOR: return p ^ q;
			default: return p;
		endcase
	endfunction : lop

	// expected floating load: shift out zero digits, underflow gives zero with the flag
	function automatic logic [32:0] fnorm(input logic [31:0] w);
		logic [23:0] f;
		int e;
		f = w[23:0];
		e = int'(w[30:24]);
		if (f == 24'h000000)
			return 33'h0;
		while (f[23:20] == 4'h0) begin
			f = f << 4;
			e = e - 1;
		end
		if (e < 0)
			return {1'b1, 32'h0};
		return {1'b0, w[31], e[6:0], f};
	endfunction : fnorm

	function automatic logic [31:0] fget(input logic [15:0] ea);
		return {odp_mem_model_inst.mem[ea[15:1]], odp_mem_model_inst.mem[ea[15:1] + 15'h1]};
	endfunction : fget

	task automatic fput(input logic [15:0] ea, input logic [31:0] w);
		odp_mem_model_inst.mem[ea[15:1]] = w[31:16];
		odp_mem_model_inst.mem[ea[15:1] + 15'h1] = w[15:0];
	endtask : fput

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] ad, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data appear in the cycle after the strobe and hold until the next read
	task automatic rd(input logic [7:0] ad, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// address field first; bounded busy poll
	task automatic exec(input logic [7:0] op, input logic [3:0] ra, input logic [3:0] rb, input logic [15:0] af);
		logic [15:0] st;
		wr(`ODP_ADR_CMD_LO, af);
		wr(`ODP_ADR_CMD_HI, {op, ra, rb});
		repeat (2) @(posedge clk);
		for (int i = 0; i < 200; i++) begin
			rd(`ODP_ADR_STATUS, st);
			if (st[`ODP_STAT_BUSY] === 1'b0)
				return;
		end
		fail_count++;
		$display("[ERR] %0t instruction never finished", $time);
		print_verdict();
	endtask : exec

	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		mem_wait = 4'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(8'h15, s);
		chk(s, 16'h0000, "unmapped read");
		rd(8'h30, s);
		chk(s, 16'h0000, "unmapped read");
		for (int k = 0; k < 16; k++) begin
			gr[k] = 16'(rnd());
			wr({`ODP_GR_PAGE, 4'(k)}, gr[k]);
		end
		$display("test register port done");
		// register logic, halfword then byte
		for (int k = 0; k < 16; k++) begin
			fn = `ODP_FN_AND + 4'(k % 4);
			cls = (k >= 8) ? `ODP_CL_BYTE : `ODP_CL_HALF;
			t = rnd();
			r1 = t[3:0];
			xr = t[7:4];
			x = (cls == `ODP_CL_BYTE) ? {8'h00, gr[r1][7:0]} : gr[r1];
			y = (cls == `ODP_CL_BYTE) ? {8'h00, gr[xr][7:0]} : gr[xr];
			exec({`ODP_LAY_RR, cls, fn}, r1, xr, 16'h0000);
			res = lop(fn, x, y);
			if (fn != `ODP_FN_CMPL)
				gr[r1] = (cls == `ODP_CL_BYTE) ? {gr[r1][15:8], res[7:0]} : res;
			rd({`ODP_GR_PAGE, r1}, s);
			chk(s, gr[r1], "logic result");
			rd(`ODP_ADR_STATUS, s);
			if (fn == `ODP_FN_CMPL)
				chk(s[1:0], {x > y, x < y}, "compare flags");
		end
		$display("test logic done");
		// indexed loads, top of memory, slow memory
		for (int k = 0; k < 4; k++) begin
			t = rnd();
			mem_wait <= t[19:16];
			xr = (k == 0) ? 4'h0 : t[7:4] | 4'h1;
			a = (k == 0) ? 16'hFFFE : {t[31:17], gr[xr][0]};
			y = (k == 0) ? a : a + gr[xr];
			r1 = t[11:8];
			odp_mem_model_inst.mem[y[15:1]] = t[15:0];
			exec({`ODP_LAY_RX, `ODP_CL_HALF, `ODP_FN_LOAD}, r1, xr, a);
			gr[r1] = t[15:0];
			rd({`ODP_GR_PAGE, r1}, s);
			chk(s, gr[r1], "indexed load");
		end
		// byte loads from the even byte of one halfword and the odd byte of another
		for (int k = 0; k < 2; k++) begin
			t = rnd();
			a = {t[31:17], 1'(k)};
			odp_mem_model_inst.mem[a[15:1]] = t[15:0];
			exec({`ODP_LAY_RX, `ODP_CL_BYTE, `ODP_FN_LOAD}, 4'h7, 4'h0, a);
			gr[7] = {8'h00, (k == 0) ? t[15:8] : t[7:0]};
			rd({`ODP_GR_PAGE, 4'h7}, s);
			chk(s, gr[7], "byte load");
		end
		$display("test loads done");
		// misaligned halfword and fullword are refused off the bus
		t = req_cycles;
		exec({`ODP_LAY_RX, `ODP_CL_HALF, `ODP_FN_LOAD}, 4'h7, 4'h0, 16'h0051);
		exec({`ODP_LAY_RX, `ODP_CL_FLOAT, `ODP_FN_LOAD}, 4'h0, 4'h0, 16'h0052);
		exec(8'hC0, 4'h0, 4'h0, 16'h0000);
		chk(req_cycles, t, "bus used");
		rd(`ODP_ADR_STATUS, s);
		chk(s[`ODP_STAT_AERR], 1'b1, "align flag");
		chk(s[`ODP_STAT_ILL], 1'b1, "illegal flag");
		wr(`ODP_ADR_STATUS, 16'h0060);
		rd(`ODP_ADR_STATUS, s);
		chk(s[`ODP_STAT_AERR], 1'b0, "align flag clear");
		chk(s[`ODP_STAT_ILL], 1'b0, "illegal flag clear");
		$display("test alignment done");
		// floating loads via odd register numbers
		for (int k = 0; k < 4; k++) begin
			t = rnd();
			v = (k == 3) ? 32'h00012345 : {t[31:24], t[23:0] >> (4 * k)};
			ne = fnorm(v);
			fput(16'h0100, v);
			exec({`ODP_LAY_RX, `ODP_CL_FLOAT, `ODP_FN_LOAD}, 4'(2 * k + 1), 4'h0, 16'h0100);
			rd(`ODP_ADR_STATUS, s);
			chk(s[`ODP_CC_V], ne[32], "load range flag");
			exec({`ODP_LAY_RX, `ODP_CL_FLOAT, `ODP_FN_STORE}, 4'(2 * k), 4'h0, 16'h0200);
			chk(fget(16'h0200), ne[31:0], "normalized load");
		end
		// overflow, underflow, cancellation
		for (int k = 0; k < 4; k++) begin
			fput(16'h0100, fa[k]);
			fput(16'h0104, fb[k]);
			exec({`ODP_LAY_RX, `ODP_CL_FLOAT, `ODP_FN_LOAD}, 4'h0, 4'h0, 16'h0100);
			exec({`ODP_LAY_RX, `ODP_CL_FLOAT, `ODP_FN_LOAD}, 4'h2, 4'h0, 16'h0104);
			exec({`ODP_LAY_RR, `ODP_CL_FLOAT, ff[k]}, 4'h1, 4'h3, 16'h0000);
			rd(`ODP_ADR_STATUS, s);
			chk(s[`ODP_CC_V], fx[k][32], "arith range flag");
			exec({`ODP_LAY_RX, `ODP_CL_FLOAT, `ODP_FN_STORE}, 4'h0, 4'h0, 16'h0200);
			chk(fget(16'h0200), fx[k][31:0], "arith result");
		end
		$display("test floating done");
		// immediate add, with and without index
		for (int k = 0; k < 2; k++) begin
			t = rnd();
			r1 = t[3:0];
			xr = (k == 0) ? 4'h0 : t[7:4] | 4'h1;
			y = t[31:16] + ((k == 0) ? 16'h0000 : gr[xr]);
			exec({`ODP_LAY_RS, `ODP_CL_HALF, `ODP_FN_ADD}, r1, xr, t[31:16]);
			gr[r1] = gr[r1] + y;
			rd({`ODP_GR_PAGE, r1}, s);
			chk(s, gr[r1], "immediate add");
		end
		$display("test immediate done");
		print_verdict();
	end
endmodule : odp_datapath_test
`default_nettype wire
